// ### design/mgrd_defines.vh
`ifndef MGRD_DEFINES_VH
`define MGRD_DEFINES_VH

`define MGRD_ADDR_IDENT      8'h40
`define MGRD_ADDR_RSVD       8'h41
`define MGRD_ADDR_X_LOW      8'h42
`define MGRD_ADDR_X_HIGH     8'h43
`define MGRD_ADDR_Y_LOW      8'h44
`define MGRD_ADDR_Y_HIGH     8'h45
`define MGRD_ADDR_Z_LOW      8'h46
`define MGRD_ADDR_Z_HIGH     8'h47
`define MGRD_ADDR_RES_LOW    8'h48
`define MGRD_ADDR_RES_HIGH   8'h49
`define MGRD_ADDR_POWER      8'h4b

`define MGRD_POWER_BIT       0
`define MGRD_FLAG_BIT        0

// arbitrary neutral identification value
`define MGRD_IDENT_VALUE     8'h5a
`define MGRD_HIDDEN_VALUE    8'h00
`define MGRD_RSVD_VALUE      8'h00
`define MGRD_FLAG_RESET      1'b1

`define MGRD_XY_WIDTH        13
`define MGRD_Z_WIDTH         15
`define MGRD_RES_WIDTH       14
`define MGRD_SAMPLE_WIDTH    58

`endif

// ### design/mgrd_skid_buffer.v
`timescale 1ns/1ps
`default_nettype none

module mgrd_skid_buffer #(
    parameter WIDTH = 8
) (
    input  wire             clk_in,
    input  wire             arst_n_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg             full0;
    reg             full1;
    reg             in_rdy;
    reg             next_full1;

    // ready is its own flop so the producer never sees a gate-derived ready
    assign in_ready_out  = in_rdy;
    assign out_valid_out = full0;
    assign out_data_out  = slot0;

    wire push = in_valid_in & in_rdy;
    wire pop  = full0 & out_ready_in;

    always @* begin
        next_full1 = full1;
        if (push && !pop && full0) begin
            next_full1 = 1'b1;
        end
        if (pop && !push) begin
            next_full1 = 1'b0;
        end
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
            full0 <= 1'b0;
            full1 <= 1'b0;
            in_rdy <= 1'b0;
        end else begin
            in_rdy <= ~next_full1;
            case ({push, pop})
                2'b10: begin
                    if (!full0) begin
                        slot0 <= in_data_in;
                        full0 <= 1'b1;
                    end else begin
                        slot1 <= in_data_in;
                        full1 <= 1'b1;
                    end
                end
                2'b01: begin
                    slot0 <= slot1;
                    full0 <= full1;
                    full1 <= 1'b0;
                end
                2'b11: begin
                    if (full1) begin
                        slot0 <= slot1;
                        slot1 <= in_data_in;
                    end else begin
                        slot0 <= in_data_in;
                    end
                end
                default: begin
                    slot0 <= slot0;
                end
            endcase
        end
    end
endmodule // mgrd_skid_buffer

`default_nettype wire

// ### design/mgrd_result_store.v
`timescale 1ns/1ps
`default_nettype none
`include "mgrd_defines.vh"

// holds the latest sample; the read port registers its byte
module mgrd_result_store (
    input  wire                           clk_in,
    input  wire                           arst_n_in,
    input  wire                           load_in,
    input  wire [`MGRD_SAMPLE_WIDTH-1:0]  sample_in,
    input  wire [7:0]                     addr_in,
    input  wire                           ready_flag_in,
    output reg  [7:0]                     rdata_out
);
    reg [`MGRD_XY_WIDTH-1:0]  x_val;
    reg [`MGRD_XY_WIDTH-1:0]  y_val;
    reg [`MGRD_Z_WIDTH-1:0]   z_val;
    reg [`MGRD_RES_WIDTH-1:0] r_val;
    reg                       x_chk;
    reg                       y_chk;
    reg                       z_chk;
    reg [7:0]                 next_rdata;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            x_val <= {`MGRD_XY_WIDTH{1'b0}};
            y_val <= {`MGRD_XY_WIDTH{1'b0}};
            z_val <= {`MGRD_Z_WIDTH{1'b0}};
            r_val <= {`MGRD_RES_WIDTH{1'b0}};
            x_chk <= `MGRD_FLAG_RESET; // R5
            y_chk <= `MGRD_FLAG_RESET; // R8
            z_chk <= `MGRD_FLAG_RESET; // R10
        end else if (load_in) begin
            {x_chk, y_chk, z_chk, x_val, y_val, z_val, r_val} <= sample_in;
        end
    end

    always @* begin
        case (addr_in)
            `MGRD_ADDR_X_LOW:    next_rdata = {x_val[4:0], 2'b00, x_chk};   // R3 R5
            `MGRD_ADDR_X_HIGH:   next_rdata = x_val[12:5];                  // R4
            `MGRD_ADDR_Y_LOW:    next_rdata = {y_val[4:0], 2'b00, y_chk};   // R6 R8
            `MGRD_ADDR_Y_HIGH:   next_rdata = y_val[12:5];                  // R7
            `MGRD_ADDR_Z_LOW:    next_rdata = {z_val[6:0], z_chk};          // R9 R10
            `MGRD_ADDR_Z_HIGH:   next_rdata = z_val[14:7];                  // R11
            `MGRD_ADDR_RES_LOW:  next_rdata = {r_val[5:0], 1'b0, ready_flag_in}; // R12 R14
            `MGRD_ADDR_RES_HIGH: next_rdata = r_val[13:6];                  // R13
            default:             next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end
endmodule // mgrd_result_store

`default_nettype wire

// ### design/mgrd_readout.v
// Overview of operation
// [R1] identification byte reads only while power control bit is one, else zero
// [R2] location after identification byte is reserved and reads zero
// [R3] x value bits 4..0 in x low byte 7..3, bits 2..1 zero
// [R4] x value bits 12..5 fill x high byte
// [R5] x check flag in x low bit 0, one after reset
// [R6] y value bits 4..0 in y low byte 7..3, bits 2..1 zero
// [R7] y value bits 12..5 fill y high byte
// [R8] y check flag in y low bit 0, one after reset
// [R9] z value bits 6..0 in z low byte 7..1
// [R10] z check flag in z low bit 0, one after reset
// [R11] z value bits 14..7 fill z high byte
// [R12] resistance bits 5..0 in resistance low 7..2, bit 1 zero
// [R13] resistance bits 13..6 fill resistance high byte
// [R14] result ready flag in resistance low byte bit 0
// [R15] host sets power control bit to leave suspend, clears to return
// [R16] writes to result, resistance and identification bytes are ignored
`timescale 1ns/1ps
`default_nettype none
`include "mgrd_defines.vh"

module mgrd_readout (
    input  wire                          CLK_SYS_IN,
    input  wire                          ARST_N_IN,
    input  wire                          SAMPLE_VALID_IN,
    output wire                          SAMPLE_READY_OUT,
    input  wire [`MGRD_SAMPLE_WIDTH-1:0] SAMPLE_DATA_IN,
    input  wire                          REG_RD_IN,
    input  wire                          REG_WR_IN,
    input  wire [7:0]                    REG_ADDR_IN,
    input  wire [7:0]                    REG_WDATA_IN,
    output reg  [7:0]                    REG_RDATA_OUT,
    output reg                           REG_RVALID_OUT,
    output reg                           POWER_ON_OUT,
    output reg                           RESULT_READY_OUT
);
    reg        power;
    reg        next_power;
    reg        ready_flag;
    reg        next_ready_flag;
    reg        rd_q;
    reg [7:0]  addr_q;
    reg [7:0]  next_rdata;
    wire       buf_valid;
    wire       buf_in_ready;
    wire       buf_out_ready;
    wire [7:0] store_rdata;
    wire [`MGRD_SAMPLE_WIDTH-1:0] buf_data;

    // request side: decoded on the edge that takes the strobe
    wire       wr_hit_power;
    wire       rd_hit_res_high;
    wire       rd_busy;
    wire       load;
    wire       drain;

    // answer side: decoded one edge later from the captured address
    wire       sel_ident;
    wire       sel_rsvd;
    wire       sel_x_low;
    wire       sel_x_high;
    wire       sel_y_low;
    wire       sel_y_high;
    wire       sel_z_low;
    wire       sel_z_high;
    wire       sel_res_low;
    wire       sel_res_high;
    wire       sel_power;
    wire       sel_result;

    assign wr_hit_power    = REG_WR_IN & (REG_ADDR_IN == `MGRD_ADDR_POWER);
    assign rd_hit_res_high = REG_RD_IN & (REG_ADDR_IN == `MGRD_ADDR_RES_HIGH);
    assign rd_busy         = REG_RD_IN | rd_q;

    // the store takes a sample only when powered and no read is mid-flight,
    // so a two-byte read with no idle cycle between its reads never mixes halves of different samples
    assign load            = buf_valid & power & ~rd_busy;

    // in suspend the buffer drains and drops samples so the producer never hangs
    assign drain           = ~power;
    assign buf_out_ready   = load | drain;

    assign sel_ident    = (addr_q == `MGRD_ADDR_IDENT);
    assign sel_rsvd     = (addr_q == `MGRD_ADDR_RSVD);
    assign sel_x_low    = (addr_q == `MGRD_ADDR_X_LOW);
    assign sel_x_high   = (addr_q == `MGRD_ADDR_X_HIGH);
    assign sel_y_low    = (addr_q == `MGRD_ADDR_Y_LOW);
    assign sel_y_high   = (addr_q == `MGRD_ADDR_Y_HIGH);
    assign sel_z_low    = (addr_q == `MGRD_ADDR_Z_LOW);
    assign sel_z_high   = (addr_q == `MGRD_ADDR_Z_HIGH);
    assign sel_res_low  = (addr_q == `MGRD_ADDR_RES_LOW);
    assign sel_res_high = (addr_q == `MGRD_ADDR_RES_HIGH);
    assign sel_power    = (addr_q == `MGRD_ADDR_POWER);
    assign sel_result   = sel_x_low | sel_x_high | sel_y_low | sel_y_high |
                          sel_z_low | sel_z_high | sel_res_low | sel_res_high;

    assign SAMPLE_READY_OUT = buf_in_ready;

    mgrd_skid_buffer #(
        .WIDTH(`MGRD_SAMPLE_WIDTH)
    ) u_buf (
        .clk_in        (CLK_SYS_IN),
        .arst_n_in     (ARST_N_IN),
        .in_valid_in   (SAMPLE_VALID_IN),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (SAMPLE_DATA_IN),
        .out_valid_out (buf_valid),
        .out_ready_in  (buf_out_ready),
        .out_data_out  (buf_data)
    );

    mgrd_result_store u_store (
        .clk_in        (CLK_SYS_IN),
        .arst_n_in     (ARST_N_IN),
        .load_in       (load),
        .sample_in     (buf_data),
        .addr_in       (REG_ADDR_IN),
        .ready_flag_in (ready_flag),
        .rdata_out     (store_rdata)
    );

    // only the power register takes writes; result bytes ignore them
    always @* begin
        next_power = power;
        if (wr_hit_power) begin
            next_power = REG_WDATA_IN[`MGRD_POWER_BIT]; // R15 R16
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            power <= 1'b0;
        end else begin
            power <= next_power;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= REG_RD_IN;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            addr_q <= 8'h00;
        end else begin
            addr_q <= REG_ADDR_IN;
        end
    end

    // a new sample wins over the clear by a read of the resistance high byte
    always @* begin
        next_ready_flag = ready_flag;
        if (load) begin
            next_ready_flag = 1'b1; // R14
        end else if (rd_hit_res_high || drain) begin
            next_ready_flag = 1'b0;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ready_flag <= 1'b0;
        end else begin
            ready_flag <= next_ready_flag;
        end
    end

    always @* begin
        if (sel_ident) begin
            next_rdata = power ? `MGRD_IDENT_VALUE : `MGRD_HIDDEN_VALUE; // R1
        end else if (sel_rsvd) begin
            next_rdata = `MGRD_RSVD_VALUE; // R2
        end else if (sel_power) begin
            next_rdata = {7'h00, power};
        end else if (sel_result) begin
            next_rdata = store_rdata;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            REG_RDATA_OUT <= 8'h00;
        end else begin
            REG_RDATA_OUT <= next_rdata;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            REG_RVALID_OUT <= 1'b0;
        end else begin
            REG_RVALID_OUT <= rd_q;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            POWER_ON_OUT <= 1'b0;
        end else begin
            POWER_ON_OUT <= power;
        end
    end

    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RESULT_READY_OUT <= 1'b0;
        end else begin
            RESULT_READY_OUT <= ready_flag;
        end
    end
endmodule // mgrd_readout

`default_nettype wire

// ### verif/mgrd_readout_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgrd_defines.vh"
module mgrd_readout_chk (
    input wire logic       CLK_SYS_IN,
    input wire logic       ARST_N_IN,
    input wire logic       SAMPLE_VALID_IN,
    input wire logic       SAMPLE_READY_OUT,
    input wire logic       REG_RD_IN,
    input wire logic       REG_WR_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic       REG_RVALID_OUT,
    input wire logic       POWER_ON_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!ARST_N_IN);
    wire       rd = REG_RD_IN;
    wire [7:0] a  = REG_ADDR_IN;
    wire [7:0] q  = REG_RDATA_OUT;
    // set once any sample is taken; until then the check flags must still read one
    logic      seen;
    always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN)
            seen <= 1'b0;
        else if (SAMPLE_VALID_IN && SAMPLE_READY_OUT)
            seen <= 1'b1;
    end
    chk_answer_two: assert property (rd |-> ##2 REG_RVALID_OUT) else $error("late");
    chk_no_spurious: assert property (!rd |-> ##2 !REG_RVALID_OUT) else $error("extra");
    chk_ident_hidden: assert property (rd && a == 8'h40
        |-> ##2 (POWER_ON_OUT || q == `MGRD_HIDDEN_VALUE)) else $error("ident seen");
    chk_ident_shown: assert property (rd && a == 8'h40
        |-> ##2 (!POWER_ON_OUT || q == `MGRD_IDENT_VALUE)) else $error("ident wrong");
    chk_rsvd_zero: assert property (rd && a == 8'h41 |-> ##2 q == 8'h00) else $error("rsvd");
    chk_x_low_fixed: assert property (rd && a == 8'h42 |-> ##2 q[2:1] == 2'b00)
        else $error("x low");
    chk_x_flag_reset: assert property (rd && a == 8'h42 && !seen |-> ##2 q[0])
        else $error("x flag");
    chk_y_low_fixed: assert property (rd && a == 8'h44 |-> ##2 q[2:1] == 2'b00)
        else $error("y low");
    chk_y_flag_reset: assert property (rd && a == 8'h44 && !seen |-> ##2 q[0])
        else $error("y flag");
    chk_z_flag_one: assert property (rd && a == 8'h46 && !seen |-> ##2 q[0])
        else $error("z flag");
    chk_res_bit_zero: assert property (rd && a == 8'h48 |-> ##2 !q[1]) else $error("res");
    chk_write_ignored: assert property (REG_WR_IN && a != 8'h4b |-> ##2 $stable(POWER_ON_OUT))
        else $error("power moved");
    cover property (rd && a == 8'h40 && POWER_ON_OUT);
    cover property (SAMPLE_VALID_IN && !SAMPLE_READY_OUT);
    cover property (REG_WR_IN && a == 8'h4b);
endmodule // mgrd_readout_chk
bind mgrd_readout mgrd_readout_chk mgrd_readout_chk_inst (.CLK_SYS_IN, .ARST_N_IN,
    .SAMPLE_VALID_IN, .SAMPLE_READY_OUT, .REG_RD_IN, .REG_WR_IN, .REG_ADDR_IN,
    .REG_RDATA_OUT, .REG_RVALID_OUT, .POWER_ON_OUT);
`default_nettype wire

// ### verif/mgrd_sample_src.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgrd_defines.vh"
module mgrd_sample_src (
    input  wire logic                          clk_in,
    input  wire logic                          arst_n_in,
    input  wire logic                          go_in,
    input  wire logic [`MGRD_SAMPLE_WIDTH-1:0] pat_in,
    input  wire logic                          ready_in,
    output var  logic                          valid_out,
    output var  logic [`MGRD_SAMPLE_WIDTH-1:0] data_out
);
    // an offer stands until taken; idle data inverts so stale words never look valid
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            valid_out <= 1'b0;
            data_out  <= '0;
        end else if (!valid_out || ready_in) begin
            valid_out <= go_in;
            data_out  <= go_in ? pat_in : ~data_out;
        end
    end
endmodule // mgrd_sample_src
`default_nettype wire

// ### verif/mgrd_readout_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mgrd_defines.vh"
`define MGRD_CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module mgrd_readout_bench;
    logic        clk = 0, rst_n = 0, go = 0, rd = 0, wr = 0;
    logic [7:0]  addr = 0, wdata = 0, rdata, rbyte;
    logic [`MGRD_SAMPLE_WIDTH-1:0] pat = 0, sdata;
    logic        svalid, sready, rvalid, pwr, rres;
    int          err_total = 0, checks_done = 0;
    always #5 clk = ~clk;
    mgrd_sample_src mgrd_sample_src_inst (.clk_in(clk), .arst_n_in(rst_n), .go_in(go),
        .pat_in(pat), .ready_in(sready), .valid_out(svalid), .data_out(sdata));
    mgrd_readout mgrd_readout_inst (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
        .SAMPLE_VALID_IN(svalid), .SAMPLE_READY_OUT(sready), .SAMPLE_DATA_IN(sdata),
        .REG_RD_IN(rd), .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .POWER_ON_OUT(pwr),
        .RESULT_READY_OUT(rres));
    task automatic reg_rd(input logic [7:0] a);
        addr = a;
        rd = 1'b1;
        @(posedge clk) #1;
        rd = 1'b0;
        @(posedge clk) #1;
        `MGRD_CHECK(rvalid, 1'b1)
        rbyte = rdata;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk) #1;
        wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic wait_res;
        for (int n = 0; n < 20 && rres !== 1'b1; n++) @(posedge clk) #1;
        `MGRD_CHECK(rres, 1'b1)
    endtask
    task automatic t_reset;
        reg_rd(8'h40);
        `MGRD_CHECK(rbyte, `MGRD_HIDDEN_VALUE)
        reg_rd(8'h41);
        `MGRD_CHECK(rbyte, `MGRD_RSVD_VALUE)
        reg_rd(8'h42);
        `MGRD_CHECK(rbyte, 8'h01)
        reg_rd(8'h44);
        `MGRD_CHECK(rbyte, 8'h01)
        reg_rd(8'h46);
        `MGRD_CHECK(rbyte, 8'h01)
        reg_rd(8'h48);
        `MGRD_CHECK(rbyte, 8'h00)
    endtask
    task automatic t_sample;
        logic [12:0] x, y;
        logic [14:0] z;
        logic [13:0] r;
        logic [7:0]  eb [0:7];
        x = 13'h1b35;
        y = 13'h0ca7;
        z = 15'h5a3c;
        r = 14'h2d59;
        eb = '{{x[4:0], 3'b001}, x[12:5], {y[4:0], 3'b000}, y[12:5],
               {z[6:0], 1'b1}, z[14:7], {r[5:0], 2'b01}, r[13:6]};
        reg_wr(`MGRD_ADDR_POWER, 8'h01);
        `MGRD_CHECK(pwr, 1'b1)
        reg_rd(`MGRD_ADDR_POWER);
        `MGRD_CHECK(rbyte, 8'h01)
        reg_rd(8'h40);
        `MGRD_CHECK(rbyte, `MGRD_IDENT_VALUE)
        pat = {3'b101, x, y, z, r};
        go = 1'b1;
        @(posedge clk) #1;
        go = 1'b0;
        wait_res;
        for (int i = 0; i < 8; i++) begin
            reg_rd(8'(8'h42 + i));
            `MGRD_CHECK(rbyte, eb[i])
        end
        `MGRD_CHECK(rres, 1'b0)
        reg_rd(8'h48);
        `MGRD_CHECK(rbyte[0], 1'b0)
        for (int i = 0; i < 10; i++) reg_wr(8'(8'h40 + i), 8'hff);
        reg_rd(8'h43);
        `MGRD_CHECK(rbyte, x[12:5])
        reg_rd(8'h40);
        `MGRD_CHECK(rbyte, `MGRD_IDENT_VALUE)
        reg_wr(`MGRD_ADDR_POWER, 8'h00);
        `MGRD_CHECK(pwr, 1'b0)
        reg_rd(8'h40);
        `MGRD_CHECK(rbyte, `MGRD_HIDDEN_VALUE)
    endtask
    // reads held back to back keep the store busy, so the buffer must fill and refuse
    task automatic t_fill;
        int low;
        low = 0;
        reg_wr(`MGRD_ADDR_POWER, 8'h01);
        pat = 58'h1c4_d3c2_b1a0_9876;
        addr = 8'h43;
        rd = 1'b1;
        @(posedge clk) #1;
        go = 1'b1;
        repeat (12) begin
            @(posedge clk) #1;
            low += (sready === 1'b0);
        end
        go = 1'b0;
        rd = 1'b0;
        `MGRD_CHECK(low > 0, 1'b1)
        repeat (8) @(posedge clk);
        #1;
        `MGRD_CHECK(sready, 1'b1)
        wait_res;
        reg_rd(8'h43);
        `MGRD_CHECK(rbyte, pat[54:47])
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset;
        t_sample;
        t_fill;
        tally_and_finish;
    end
    initial begin
        #20000;
        err_total++;
        tally_and_finish;
    end
endmodule // mgrd_readout_bench
`default_nettype wire
